// ==== rtl/tick_pkg.sv ====
package tick_pkg;

	localparam logic [31:0] CSR_ADDR        = 32'hE000E010;
	localparam logic [31:0] RELOAD_ADDR     = 32'hE000E014;
	localparam logic [31:0] CURRENT_ADDR    = 32'hE000E018;
	localparam logic [31:0] IRQ_STATUS_ADDR = 32'hE000E01C;
	localparam logic [31:0] IRQ_MASK_ADDR   = 32'hE000E020;

	localparam int COUNT_WIDTH = 24;
	localparam int EVENT_COUNT = 1;

	localparam int ENABLE_BIT  = 0;
	localparam int INT_ENABLE_BIT = 1;
	localparam int CLKSEL_BIT  = 2;
	localparam int FLAG_BIT    = 16;
	localparam int TICK_EVENT_BIT = 0;

	localparam logic [23:0] RELOAD_RESET  = 24'h000000;
	localparam logic [23:0] COUNT_RESET   = 24'h000000;
	localparam logic        CTRL_RESET    = 1'h0;
	localparam logic        FLAG_RESET    = 1'h0;
	localparam logic [0:0]  MASK_RESET    = 1'h1;
	localparam logic [0:0]  STATUS_RESET  = 1'h0;

	typedef enum logic [2:0] {
		SEL_CSR,
		SEL_RELOAD,
		SEL_CURRENT,
		SEL_STATUS,
		SEL_MASK,
		SEL_NONE
	} reg_sel_type;

	function automatic reg_sel_type decode_addr(input logic [31:0] addr);
		reg_sel_type sel;
		sel = SEL_NONE;
		if (addr == CSR_ADDR)
			sel = SEL_CSR;
		else if (addr == RELOAD_ADDR)
			sel = SEL_RELOAD;
		else if (addr == CURRENT_ADDR)
			sel = SEL_CURRENT;
		else if (addr == IRQ_STATUS_ADDR)
			sel = SEL_STATUS;
		else if (addr == IRQ_MASK_ADDR)
			sel = SEL_MASK;
		return sel;
	endfunction

endpackage

// ==== rtl/tick_reg_if.sv ====
`timescale 1ns/1ps
interface tick_reg_if;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        hit;
	logic        rd_sample;
	logic        rd_done;
	logic        wr_stb;

	modport port
	(
		output addr,
		output wdata,
		output rd_sample,
		output rd_done,
		output wr_stb,
		input  rdata,
		input  hit
	);

	modport regs
	(
		input  addr,
		input  wdata,
		input  rd_sample,
		input  rd_done,
		input  wr_stb,
		output rdata,
		output hit
	);
endinterface

// ==== rtl/apb_reg_port.sv ====
`timescale 1ns/1ps
module apb_reg_port
	import tick_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	tick_reg_if.port         rf
);

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} port_state_type;

	port_state_type s_reg;
	port_state_type s_next;
	logic           setup;
	logic           done;

	// Read data is sampled in setup so pready can come from a flop
	always_comb
	begin
		setup = psel & ~penable & ~s_reg.pready;
		done = psel & penable & s_reg.pready;
		rf.addr = paddr;
		rf.wdata = pwdata;
		rf.rd_sample = setup & ~pwrite;
		rf.rd_done = done & ~pwrite & ~s_reg.pslverr;
		rf.wr_stb = done & pwrite & ~s_reg.pslverr;
		s_next = s_reg;
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		s_next.prdata = 32'h00000000;
		if (setup)
		begin
			s_next.pready = 1'b1;
			s_next.pslverr = ~rf.hit;
			s_next.prdata = (pwrite | ~rf.hit) ? 32'h00000000 : rf.rdata;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;

endmodule

// ==== rtl/tick_irq_gate.sv ====
`timescale 1ns/1ps
module tick_irq_gate
	import tick_pkg::*;
#(
	parameter int WIDTH = EVENT_COUNT
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] event_pulse,
	input  wire logic             status_sample,
	input  wire logic             status_read,
	input  wire logic             mask_write,
	input  wire logic [WIDTH-1:0] mask_data,
	output logic      [WIDTH-1:0] status,
	output logic      [WIDTH-1:0] mask,
	output logic                  irq
);

	typedef struct packed {
		logic [WIDTH-1:0] status;
		logic [WIDTH-1:0] seen;
		logic [WIDTH-1:0] mask;
		logic             irq;
	} gate_state_type;

	gate_state_type s_reg;
	gate_state_type s_next;

	always_comb
	begin
		s_next = s_reg;
		if (status_sample)
			s_next.seen = s_reg.status;
		if (mask_write)
			s_next.mask = mask_data;
		// Only bits the read returned are cleared; a new event wins
		for (int i = 0; i < WIDTH; i++)
		begin
			if (status_read && s_reg.seen[i])
				s_next.status[i] = 1'b0;
			if (event_pulse[i])
				s_next.status[i] = 1'b1;
		end
		s_next.irq = |(s_next.status & s_next.mask);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_reg.status <= WIDTH'(STATUS_RESET);
			s_reg.seen <= '0;
			s_reg.mask <= WIDTH'(MASK_RESET);
			s_reg.irq <= 1'b0;
		end
		else
			s_reg <= s_next;
	end

	assign status = s_reg.status;
	assign mask = s_reg.mask;
	assign irq = s_reg.irq;

endmodule

// ==== rtl/tick_timer.sv ====
`timescale 1ns/1ps
module tick_timer
	import tick_pkg::*;
#(
	parameter int WIDTH = COUNT_WIDTH
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic [WIDTH-1:0] reload;
		logic             enable;
		logic             tick_interrupt_enable;
		logic             count_clock_select;
		logic             zero_reached_flag;
		logic             flag_seen;
	} timer_state_type;

	timer_state_type s_reg;
	timer_state_type s_next;

	tick_reg_if rf ();

	reg_sel_type          rd_sel;
	reg_sel_type          wr_sel;
	logic                 zero_event;
	logic                 cur_write;
	logic [EVENT_COUNT-1:0] events;
	logic [EVENT_COUNT-1:0] irq_status;
	logic [EVENT_COUNT-1:0] irq_mask;

	apb_reg_port u_port
	(
		.clk     (clk),
		.rst     (rst),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rf      (rf.port)
	);

	// No wake path
	// The interrupt is a plain level; nothing here leaves standby.
	tick_irq_gate #(.WIDTH(EVENT_COUNT)) u_irq
	(
		.clk           (clk),
		.rst           (rst),
		.event_pulse   (events),
		.status_sample (rf.rd_sample && rd_sel == SEL_STATUS),
		.status_read   (rf.rd_done && rd_sel == SEL_STATUS),
		.mask_write    (rf.wr_stb && wr_sel == SEL_MASK),
		.mask_data     (rf.wdata[EVENT_COUNT-1:0]),
		.status        (irq_status),
		.mask          (irq_mask),
		.irq           (irq)
	);

	// Read mux
	always_comb
	begin
		rd_sel = decode_addr(rf.addr);
		rf.hit = (rd_sel != SEL_NONE);
		rf.rdata = 32'h00000000;
		unique case (rd_sel)
			SEL_CSR:
			begin
				rf.rdata[FLAG_BIT] = s_reg.zero_reached_flag;
				rf.rdata[CLKSEL_BIT] = s_reg.count_clock_select;
				rf.rdata[INT_ENABLE_BIT] = s_reg.tick_interrupt_enable;
				rf.rdata[ENABLE_BIT] = s_reg.enable;
			end
			SEL_RELOAD:
				rf.rdata[WIDTH-1:0] = s_reg.reload;
			SEL_CURRENT:
				rf.rdata[WIDTH-1:0] = s_reg.count;
			SEL_STATUS:
				rf.rdata[EVENT_COUNT-1:0] = irq_status;
			SEL_MASK:
				rf.rdata[EVENT_COUNT-1:0] = irq_mask;
			SEL_NONE:
				rf.rdata = 32'h00000000;
		endcase
	end

	// Next state
	always_comb
	begin
		wr_sel = rf.wr_stb ? decode_addr(rf.addr) : SEL_NONE;
		cur_write = (wr_sel == SEL_CURRENT);
		zero_event = 1'b0;
		s_next = s_reg;

		// Down count
		// Count select 0 is reserved, so only bit 0 gates the count.
		if (s_reg.enable)
		begin
			if (s_reg.count == '0)
				// Reload step
				// Reload counts as a step, giving a period of reload+1.
				s_next.count = s_reg.reload;
			else
			begin
				s_next.count = s_reg.count - WIDTH'(1);
				if (s_reg.count == WIDTH'(1))
					zero_event = 1'b1;
			end
		end

		// Write clears count
		// A software clear beats a zero arriving in the same cycle.
		if (cur_write)
		begin
			s_next.count = '0;
			zero_event = 1'b0;
		end

		if (wr_sel == SEL_CSR)
		begin
			s_next.enable = rf.wdata[ENABLE_BIT];
			s_next.tick_interrupt_enable = rf.wdata[INT_ENABLE_BIT];
			s_next.count_clock_select = rf.wdata[CLKSEL_BIT];
		end

		if (wr_sel == SEL_RELOAD)
			s_next.reload = rf.wdata[WIDTH-1:0];

		// Clear on read
		// A read clears only a flag it returned; a write to the current count clears it too.
		if (rf.rd_sample && rd_sel == SEL_CSR)
			s_next.flag_seen = s_reg.zero_reached_flag;
		if (rf.rd_done && rd_sel == SEL_CSR && s_reg.flag_seen)
			s_next.zero_reached_flag = 1'b0;
		if (cur_write)
			s_next.zero_reached_flag = 1'b0;
		if (zero_event)
			s_next.zero_reached_flag = 1'b1;
	end

	always_comb
	begin
		events = '0;
		events[TICK_EVENT_BIT] = zero_event & s_reg.tick_interrupt_enable;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_reg.count <= WIDTH'(COUNT_RESET);
			s_reg.reload <= WIDTH'(RELOAD_RESET);
			s_reg.enable <= CTRL_RESET;
			s_reg.tick_interrupt_enable <= CTRL_RESET;
			s_reg.count_clock_select <= CTRL_RESET;
			s_reg.zero_reached_flag <= FLAG_RESET;
			s_reg.flag_seen <= 1'b0;
		end
		else
			s_reg <= s_next;
	end

endmodule

// ==== bench/tick_timer_monitor.sv ====
`timescale 1ns/1ps
module tick_timer_monitor
	import tick_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	logic map;
	logic rd;
	// Address is held through the access phase, so decode it live
	assign map = paddr inside {CSR_ADDR, RELOAD_ADDR, CURRENT_ADDR,
		IRQ_STATUS_ADDR, IRQ_MASK_ADDR};
	assign rd = pready && !pwrite;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_setup_ready; psel && !penable |=> pready; endproperty
	a_setup_ready: assert property (p_setup_ready)
		else $error("no ready after setup");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready held too long");
	property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
	a_idle_zero: assert property (p_idle_zero)
		else $error("read data outside answer");
	property p_unmapped; pready && !map |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	property p_mapped; pready && map |-> !pslverr; endproperty
	a_mapped: assert property (p_mapped)
		else $error("mapped access refused");
	property p_csr_res;
		rd && paddr == CSR_ADDR |-> prdata[31:17] == 15'h0
			&& prdata[15:3] == 13'h0;
	endproperty
	a_csr_res: assert property (p_csr_res)
		else $error("control reserved bits set");
	property p_width;
		rd && (paddr == RELOAD_ADDR || paddr == CURRENT_ADDR)
			|-> prdata[31:24] == 8'h0;
	endproperty
	a_width: assert property (p_width)
		else $error("count upper bits set");
	property p_mask_off;
		pready && pwrite && paddr == IRQ_MASK_ADDR && !pwdata[0]
			|-> ##2 !irq;
	endproperty
	a_mask_off: assert property (p_mask_off)
		else $error("masked interrupt still high");
endmodule

// ==== bench/tick_timer_tb.sv ====
`timescale 1ns/1ps
module tick_timer_tb
	import tick_pkg::*;
();
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] r;
	logic [31:0] r2;
	logic        e;
	int          fail_count;
	int          n_compared;
	int          cyc;
	int          t0;

	tick_timer dut
	(
		.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq)
	);

	always #10 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	task automatic chk(input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x)
		begin
			fail_count++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, x, g);
		end
	endtask

	// One idle edge first, so release and next setup never share a step
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, r, e);
		chk(x, r);
		chk(32'h0, 32'(e));
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r, e);
		chk(32'h0, 32'(e));
	endtask

	task automatic wirq(input logic v);
		int n;
		n = 0;
		while (irq !== v && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		chk(32'(v), 32'(irq));
	endtask

	task final_report;
		if (fail_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		{clk, psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(CSR_ADDR, 32'h0);
		rd(RELOAD_ADDR, 32'(RELOAD_RESET));
		rd(CURRENT_ADDR, 32'(COUNT_RESET));
		rd(IRQ_STATUS_ADDR, 32'h0);
		rd(IRQ_MASK_ADDR, 32'h1);
		apb(1'b0, 32'hE000E024, 32'h0, r, e);
		chk(32'h1, 32'(e));
		chk(32'h0, r);
		apb(1'b1, 32'hE000E024, 32'hFFFFFFFF, r, e);
		chk(32'h1, 32'(e));
		wr(CSR_ADDR, 32'hFFFFFFFF);
		rd(CSR_ADDR, 32'h00000007);
		wr(RELOAD_ADDR, 32'hFFFFFFFF);
		rd(RELOAD_ADDR, 32'h00FFFFFF);
		wr(CSR_ADDR, 32'h0);
		apb(1'b0, CURRENT_ADDR, 32'h0, r2, e);
		chk(32'h1, 32'(r2 > 32'h00FFFF00 && r2 < 32'h01000000));
		rd(CURRENT_ADDR, r2);
		wr(CURRENT_ADDR, 32'h12345678);
		rd(CURRENT_ADDR, 32'h0);
		wr(RELOAD_ADDR, 32'h00000009);
		wr(CSR_ADDR, 32'h1);
		repeat (25) @(posedge clk);
		wr(CSR_ADDR, 32'h0);
		chk(32'h0, 32'(irq));
		rd(IRQ_STATUS_ADDR, 32'h0);
		rd(CSR_ADDR, 32'h00010000);
		rd(CSR_ADDR, 32'h0);
		wr(CSR_ADDR, 32'h1);
		repeat (25) @(posedge clk);
		wr(CSR_ADDR, 32'h0);
		wr(CURRENT_ADDR, 32'h0);
		rd(CSR_ADDR, 32'h0);
		wr(CSR_ADDR, 32'h7);
		wirq(1'b1);
		t0 = cyc;
		rd(IRQ_STATUS_ADDR, 32'h1);
		wirq(1'b0);
		wirq(1'b1);
		chk(32'h0000000A, 32'(cyc - t0));
		wr(IRQ_MASK_ADDR, 32'h0);
		repeat (25) @(posedge clk);
		chk(32'h0, 32'(irq));
		wr(CSR_ADDR, 32'h0);
		wr(IRQ_MASK_ADDR, 32'h1);
		wirq(1'b1);
		rd(IRQ_STATUS_ADDR, 32'h1);
		wirq(1'b0);
		// Reset in mid-run, with the counter live, must restore the control, reload, count and status defaults
		wr(CSR_ADDR, 32'h7);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk(32'h0, 32'(irq));
		rd(CSR_ADDR, 32'h0);
		rd(RELOAD_ADDR, 32'(RELOAD_RESET));
		rd(CURRENT_ADDR, 32'(COUNT_RESET));
		rd(IRQ_STATUS_ADDR, 32'h0);
		final_report;
	end

	// A few hundred cycles are needed; this cuts a hang short
	initial
	begin
		#100000;
		fail_count++;
		final_report;
	end
endmodule

bind tick_timer tick_timer_monitor mon
(
	.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq)
);
